/* File: rtl/acca_alert_cmp.sv */
// digital limit comparator with consecutive count and alert hold
`timescale 1ns/10ps
`include "acca_params.svh"
module acca_alert_cmp (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic eval,
  input wire acca_pkg::acca_word_t sample,
  input wire acca_pkg::acca_word_t upper_limit,
  input wire acca_pkg::acca_word_t lower_limit,
  input wire logic window_style,
  input wire logic alert_hold,
  input wire logic [1:0] alert_count_select,
  input wire logic clear,
  output logic alert,
  output logic over_flag
);
  import acca_pkg::*;
  logic above;
  logic below;
  logic beyond;
  logic [2:0] hits;
  logic [2:0] need;
  logic off;
  logic trip;
  logic release_now;

  // ==================================================
  // signed limit tests on the result being written
  assign above = $signed(sample) > $signed(upper_limit);
  assign below = $signed(sample) < $signed(lower_limit);
  assign beyond = window_style ? (above || below) : above;
  assign off = (alert_count_select == `ACCA_COUNT_OFF);
  always_comb begin
    unique case (alert_count_select)
      `ACCA_COUNT_ONE: need = `ACCA_TRIP_ONE;
      `ACCA_COUNT_TWO: need = `ACCA_TRIP_TWO;
      default: need = `ACCA_TRIP_FOUR;
    endcase
  end
  assign trip = eval && beyond && ((hits + 3'h1) >= need);
  // traditional style drops only below the lower limit: hysteresis
  assign release_now = eval && !alert_hold &&
                       (window_style ? !beyond : below);

  // ==================================================
  // consecutive out-of-limit results, saturating at the trip count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hits <= '0;
    end else if (off) begin
      hits <= '0;
    end else if (eval) begin
      hits <= !beyond ? '0 : (hits >= need) ? need : hits + 3'h1;
    end
  end

  // a new trip wins over a clear arriving in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alert <= 1'b0;
    end else if (off) begin
      alert <= 1'b0;
    end else if (trip) begin
      alert <= 1'b1;
    end else if (release_now || (clear && alert_hold)) begin
      alert <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      over_flag <= 1'b0;
    end else if (trip) begin
      over_flag <= above;
    end
  end
endmodule // acca_alert_cmp

/* File: rtl/acca_params.svh */
// constants of the converter control block: offsets, fields, timing
`ifndef ACCA_PARAMS_SVH
`define ACCA_PARAMS_SVH
// ==================================================
// clocks and timing
`define ACCA_CLK_HZ 50000000
`define ACCA_OSC_HZ 1000000
`define ACCA_MOD_DIV 4
`define ACCA_US_PER_S 1000000
`define ACCA_WAKE_US 25
`define ACCA_READY_US 8
// ==================================================
// register byte offsets
`define ACCA_OFS_CONFIG 12'h000
`define ACCA_OFS_RESULT 12'h004
`define ACCA_OFS_UPPER 12'h008
`define ACCA_OFS_LOWER 12'h00c
`define ACCA_OFS_STATUS 12'h010
// ==================================================
// reset values
`define ACCA_CONFIG_RST 16'h0583
`define ACCA_UPPER_RST 16'h7fff
`define ACCA_LOWER_RST 16'h8000
// ==================================================
// configuration fields
`define ACCA_F_START 15
`define ACCA_F_INSEL 14:12
`define ACCA_F_RANGE 11:9
`define ACCA_F_MODE 8
`define ACCA_F_RATE 7:5
`define ACCA_F_STYLE 4
`define ACCA_F_POL 3
`define ACCA_F_HOLD 2
`define ACCA_F_COUNT 1:0
`define ACCA_F_MSB 15
// status fields
`define ACCA_S_BUSY 0
`define ACCA_S_ALERT 1
`define ACCA_S_OVER 2
`define ACCA_S_READY 3
`define ACCA_S_PIN 4
// ==================================================
// alert count codes and trip counts
`define ACCA_COUNT_OFF 2'b11
`define ACCA_COUNT_ONE 2'b00
`define ACCA_COUNT_TWO 2'b01
`define ACCA_TRIP_ONE 3'h1
`define ACCA_TRIP_TWO 3'h2
`define ACCA_TRIP_FOUR 3'h4
// ==================================================
// data rates in samples per second, by rate_select code
`define ACCA_SPS_0 8
`define ACCA_SPS_1 16
`define ACCA_SPS_2 32
`define ACCA_SPS_3 64
`define ACCA_SPS_4 128
`define ACCA_SPS_5 250
`define ACCA_SPS_6 475
`define ACCA_SPS_7 860
// ==================================================
// full-scale spans and lsb weight in picovolts
`define ACCA_RANGE_LAST 3'h5
`define ACCA_LSB_0 28'd187500000
`define ACCA_LSB_1 28'd125000000
`define ACCA_LSB_2 28'd62500000
`define ACCA_LSB_3 28'd31250000
`define ACCA_LSB_4 28'd15625000
`define ACCA_LSB_5 28'd7812500
`endif

/* File: rtl/acca_pkg.sv */
// types shared by the converter control block
package acca_pkg;
  typedef logic [15:0] acca_word_t;
  typedef enum logic [1:0] {st_off, st_wake, st_conv} acca_state_t;
endpackage

/* File: rtl/acca_tick_gen.sv */
// oscillator and modulator tick enables derived from the system clock
`timescale 1ns/10ps
module acca_tick_gen #(
  parameter int unsigned CLK_PER_OSC = 50,
  parameter int unsigned MOD_DIV = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic osc_tick,
  output logic mod_tick
);
  localparam int OW = $clog2(CLK_PER_OSC + 1);
  localparam int MW = $clog2(MOD_DIV + 1);
  localparam logic [OW-1:0] OSC_LAST = OW'(CLK_PER_OSC - 1);
  localparam logic [MW-1:0] MOD_LAST = MW'(MOD_DIV - 1);
  logic [OW-1:0] osc_cnt;
  logic [MW-1:0] mod_cnt;

  // ==================================================
  // 1 MHz oscillator enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt <= '0;
    end else if (osc_cnt == OSC_LAST) begin
      osc_cnt <= '0;
    end else begin
      osc_cnt <= osc_cnt + 1'b1;
    end
  end
  assign osc_tick = (osc_cnt == OSC_LAST);

  // ==================================================
  // modulator enable: every fourth oscillator tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mod_cnt <= '0;
    end else if (osc_tick) begin
      mod_cnt <= (mod_cnt == MOD_LAST) ? '0 : mod_cnt + 1'b1;
    end
  end
  assign mod_tick = osc_tick && (mod_cnt == MOD_LAST);
endmodule // acca_tick_gen

/* File: rtl/acca_top.sv */
// converter control: apb registers, conversion sequencing, alert pin
// ==================================================
// Functional notes
// - input_select picks four single-ended, two pairs, or inputs 0/1 vs 3
// - single-ended choices tie the negative input to ground
// - without multiplexer, positive is input zero, negative input one
// - modulator clock is the 1 MHz oscillator divided by four
// - no external clock; all conversion timing from the oscillator
// - range_select picks six spans, lsb weight is span over 65536
// - rate_select picks one of eight data rates, 8 to 860 per second
// - conversion time is one period of the selected data rate
// - traditional style sets above upper, drops only below lower
// - window style alerts above upper or below lower limit
// - alert_polarity picks pin active level, active low by default
// - alert_hold keeps an asserted alert after results return
// - a held alert clears on alert response win or result read
// - alert_count_select needs one, two, four hits; 11b disables pin
// - limit msbs 1 and 0 with count not 11b make a ready pin
// - in ready operation style and hold bits do nothing
// - in ready operation polarity still sets the active level
// - continuous mode gives a short ready pulse after every result
// - start flag wakes device, flag clears, one conversion, sleep
// - continuous stores each result, new settings at next conversion
// - alert response: lowest address wins and clears, others keep
// - in window style response status is 1 upper, 0 lower
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "acca_params.svh"
module acca_top #(
  parameter bit HAS_MUX = 1'b1,
  parameter int unsigned CLK_PER_OSC = `ACCA_CLK_HZ / `ACCA_OSC_HZ,
  parameter int unsigned MOD_HZ = `ACCA_OSC_HZ / `ACCA_MOD_DIV
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire acca_pkg::acca_word_t conv_data,
  input wire logic ara_cmd,
  input wire logic ara_won,
  output logic ara_pending,
  output logic ara_status,
  input wire logic alert_i,
  output logic alert_o,
  output logic alert_oe,
  output logic [1:0] positive_input,
  output logic [1:0] negative_input,
  output logic neg_ground,
  output logic [2:0] full_scale_span,
  output logic [27:0] lsb_pv,
  output logic modulator_clock_en,
  output logic converting,
  output logic conv_done
);
  import acca_pkg::*;

  localparam logic [7:0] WAKE_TICKS =
    8'(`ACCA_WAKE_US * `ACCA_OSC_HZ / `ACCA_US_PER_S);
  localparam logic [7:0] READY_TICKS =
    8'(`ACCA_READY_US * `ACCA_OSC_HZ / `ACCA_US_PER_S);

  logic osc_tick;
  logic mod_tick;
  logic [14:0] cfg;
  acca_word_t upper_limit;
  acca_word_t lower_limit;
  acca_word_t result;
  logic start_pending;
  acca_state_t state;
  acca_state_t next_state;
  logic [7:0] wake_cnt;
  logic [23:0] conv_cnt;
  logic [23:0] conv_len;
  logic [2:0] act_rate;
  logic [2:0] act_range;
  logic [2:0] act_insel;
  logic ready;
  logic ready_hold;
  logic [7:0] ready_cnt;
  logic alert;
  logic over_flag;
  logic pin_meta;
  logic pin_sync;
  logic setup;
  logic access;
  logic wr;
  logic rd_result;
  logic wake_done;
  logic conv_end;
  logic load_cfg;
  logic single_mode;
  logic rdy_mode;
  logic count_off;
  logic pin_active;
  logic pin_level;

  // ==================================================
  // decoders
  function automatic logic mapped(input logic [11:0] a);
    return (a == `ACCA_OFS_CONFIG) || (a == `ACCA_OFS_RESULT) ||
           (a == `ACCA_OFS_UPPER) || (a == `ACCA_OFS_LOWER) ||
           (a == `ACCA_OFS_STATUS);
  endfunction

  function automatic logic [23:0] rate_ticks(input logic [2:0] r);
    int unsigned sps;
    sps = `ACCA_SPS_0;
    unique case (r)
      3'h0: sps = `ACCA_SPS_0;
      3'h1: sps = `ACCA_SPS_1;
      3'h2: sps = `ACCA_SPS_2;
      3'h3: sps = `ACCA_SPS_3;
      3'h4: sps = `ACCA_SPS_4;
      3'h5: sps = `ACCA_SPS_5;
      3'h6: sps = `ACCA_SPS_6;
      3'h7: sps = `ACCA_SPS_7;
    endcase
    return 24'(MOD_HZ / sps);
  endfunction

  // returns {positive, negative, ground switch}
  function automatic logic [4:0] route(input logic [2:0] s);
    logic [4:0] v;
    v = {2'h0, 2'h1, 1'b0};
    if (HAS_MUX) begin
      unique case (s)
        3'h0: v = {2'h0, 2'h1, 1'b0};
        3'h1: v = {2'h0, 2'h3, 1'b0};
        3'h2: v = {2'h1, 2'h3, 1'b0};
        3'h3: v = {2'h2, 2'h3, 1'b0};
        3'h4: v = {2'h0, 2'h0, 1'b1};
        3'h5: v = {2'h1, 2'h0, 1'b1};
        3'h6: v = {2'h2, 2'h0, 1'b1};
        3'h7: v = {2'h3, 2'h0, 1'b1};
      endcase
    end
    return v;
  endfunction

  function automatic logic [27:0] lsb_of(input logic [2:0] r);
    logic [27:0] w;
    w = `ACCA_LSB_5;
    unique case (r)
      3'h0: w = `ACCA_LSB_0;
      3'h1: w = `ACCA_LSB_1;
      3'h2: w = `ACCA_LSB_2;
      3'h3: w = `ACCA_LSB_3;
      3'h4: w = `ACCA_LSB_4;
      default: w = `ACCA_LSB_5;
    endcase
    return w;
  endfunction

  // ==================================================
  // timebase from the internal oscillator only
  acca_tick_gen #(
    .CLK_PER_OSC(CLK_PER_OSC),
    .MOD_DIV(`ACCA_MOD_DIV)
  ) u_ticks (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .osc_tick(osc_tick),
    .mod_tick(mod_tick)
  );
  assign modulator_clock_en = mod_tick;

  // ==================================================
  // apb slave: zero wait states, error on unmapped offsets
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access && !mapped(paddr);
  assign wr = access && pwrite && mapped(paddr);
  assign rd_result = access && !pwrite && (paddr == `ACCA_OFS_RESULT);
  assign single_mode = cfg[`ACCA_F_MODE];

  // read data are captured in the setup phase, valid in the access phase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (setup) begin
      case (paddr)
        `ACCA_OFS_CONFIG: prdata <= {16'h0, start_pending, cfg};
        `ACCA_OFS_RESULT: prdata <= {16'h0, result};
        `ACCA_OFS_UPPER: prdata <= {16'h0, upper_limit};
        `ACCA_OFS_LOWER: prdata <= {16'h0, lower_limit};
        `ACCA_OFS_STATUS: begin
          prdata <= '0;
          prdata[`ACCA_S_BUSY] <= (state != st_off);
          prdata[`ACCA_S_ALERT] <= alert;
          prdata[`ACCA_S_OVER] <= over_flag;
          prdata[`ACCA_S_READY] <= ready;
          prdata[`ACCA_S_PIN] <= pin_sync;
        end
        default: prdata <= '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= 15'(`ACCA_CONFIG_RST);
    end else if (wr && (paddr == `ACCA_OFS_CONFIG)) begin
      cfg <= pwdata[14:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      upper_limit <= `ACCA_UPPER_RST;
      lower_limit <= `ACCA_LOWER_RST;
    end else if (wr) begin
      if (paddr == `ACCA_OFS_UPPER) begin
        upper_limit <= pwdata[15:0];
      end
      if (paddr == `ACCA_OFS_LOWER) begin
        lower_limit <= pwdata[15:0];
      end
    end
  end

  // a start written while awake or converting is dropped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_pending <= 1'b0;
    end else if (wake_done) begin
      start_pending <= 1'b0;
    end else if (wr && (paddr == `ACCA_OFS_CONFIG) &&
                 pwdata[`ACCA_F_START] && (state == st_off)) begin
      start_pending <= 1'b1;
    end
  end

  // ==================================================
  // conversion sequencing
  assign wake_done = (state == st_wake) && osc_tick &&
                     (wake_cnt == WAKE_TICKS - 8'h1);
  assign conv_len = rate_ticks(act_rate);
  assign conv_end = (state == st_conv) && mod_tick &&
                    (conv_cnt == conv_len - 24'h1);
  // settings are sampled only at a conversion boundary
  assign load_cfg = wake_done || (conv_end && !single_mode);

  always_comb begin
    next_state = state;
    unique case (state)
      st_off: begin
        if (start_pending || !single_mode) begin
          next_state = st_wake;
        end
      end
      st_wake: begin
        if (wake_done) begin
          next_state = st_conv;
        end
      end
      st_conv: begin
        if (conv_end && single_mode) begin
          next_state = st_off;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_off;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt <= '0;
    end else if (state != st_wake) begin
      wake_cnt <= '0;
    end else if (osc_tick) begin
      wake_cnt <= wake_cnt + 8'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt <= '0;
    end else if (state != st_conv || conv_end) begin
      conv_cnt <= '0;
    end else if (mod_tick) begin
      conv_cnt <= conv_cnt + 24'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_rate <= 3'(`ACCA_CONFIG_RST >> 5);
      act_range <= 3'(`ACCA_CONFIG_RST >> 9);
      act_insel <= '0;
    end else if (load_cfg) begin
      act_rate <= cfg[`ACCA_F_RATE];
      act_range <= cfg[`ACCA_F_RANGE];
      act_insel <= cfg[`ACCA_F_INSEL];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result <= '0;
    end else if (conv_end) begin
      result <= conv_data;
    end
  end

  // ==================================================
  // analog steering, held while a conversion runs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      positive_input <= '0;
      negative_input <= 2'h1;
      neg_ground <= 1'b0;
      full_scale_span <= '0;
      lsb_pv <= '0;
    end else if (load_cfg) begin
      {positive_input, negative_input, neg_ground} <=
        route(cfg[`ACCA_F_INSEL]);
      // codes above the last span fall back to the smallest span
      full_scale_span <= (cfg[`ACCA_F_RANGE] > `ACCA_RANGE_LAST) ?
                         `ACCA_RANGE_LAST : cfg[`ACCA_F_RANGE];
      lsb_pv <= lsb_of(cfg[`ACCA_F_RANGE]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      converting <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      converting <= (next_state == st_conv);
      conv_done <= conv_end;
    end
  end

  // ==================================================
  // conversion-ready signal
  assign count_off = (cfg[`ACCA_F_COUNT] == `ACCA_COUNT_OFF);
  assign rdy_mode = upper_limit[`ACCA_F_MSB] && !lower_limit[`ACCA_F_MSB] &&
                    !count_off;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
      ready_hold <= 1'b0;
      ready_cnt <= '0;
    end else if (conv_end) begin
      ready <= 1'b1;
      ready_hold <= single_mode;
      ready_cnt <= '0;
    end else if (ready_hold) begin
      // single-shot ready stays until the next wake-up
      if (state == st_wake) begin
        ready <= 1'b0;
        ready_hold <= 1'b0;
      end
    end else if (ready && osc_tick) begin
      ready_cnt <= ready_cnt + 8'h1;
      if (ready_cnt == READY_TICKS - 8'h1) begin
        ready <= 1'b0;
      end
    end
  end

  // ==================================================
  // limit comparator and alert response
  acca_alert_cmp u_cmp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .eval(conv_end),
    .sample(conv_data),
    .upper_limit(upper_limit),
    .lower_limit(lower_limit),
    .window_style(cfg[`ACCA_F_STYLE]),
    .alert_hold(cfg[`ACCA_F_HOLD]),
    .alert_count_select(cfg[`ACCA_F_COUNT]),
    .clear(rd_result || (ara_cmd && ara_won)),
    .alert(alert),
    .over_flag(over_flag)
  );
  // only a held alert answers; losing arbitration keeps it
  assign ara_pending = alert && cfg[`ACCA_F_HOLD] && !rdy_mode;
  assign ara_status = over_flag;

  // ==================================================
  // open-drain alert pin, released high when disabled
  assign pin_active = rdy_mode ? ready : alert;
  assign pin_level = cfg[`ACCA_F_POL] ? pin_active : !pin_active;
  assign alert_o = 1'b0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alert_oe <= 1'b0;
    end else begin
      alert_oe <= !count_off && !pin_level;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= alert_i;
      pin_sync <= pin_meta;
    end
  end
endmodule // acca_top

/* File: tb/acca_host_model.sv */
// host side: samples passed through as results, pulled-up alert pin, alert response
`timescale 1ns/10ps
module acca_host_model (
  input wire logic clk_sys,
  input wire acca_pkg::acca_word_t sample,
  input wire logic alert_oe,
  output acca_pkg::acca_word_t conv_data,
  output logic alert_i,
  output logic ara_cmd,
  output logic ara_won
);
  import acca_pkg::*;
  // ==========
  // released pin reads high through the pull-up
  assign alert_i = alert_oe ? 1'b0 : 1'b1;
  assign conv_data = sample;
  initial begin
    ara_cmd = 1'b0;
    ara_won = 1'b0;
  end
  // one alert response; won means our address had the lowest value
  task automatic respond(input logic won);
    @(posedge clk_sys);
    ara_cmd <= 1'b1;
    ara_won <= won;
    @(posedge clk_sys);
    ara_cmd <= 1'b0;
    ara_won <= 1'b0;
  endtask
endmodule // acca_host_model

/* File: tb/acca_top_props.sv */
// port checks of the converter control block
`timescale 1ns/10ps
`include "acca_params.svh"
module acca_top_props #(
  parameter int unsigned CLK_PER_OSC = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic conv_done,
  input wire logic converting,
  input wire logic ara_pending,
  input wire logic ara_status,
  input wire logic ara_cmd,
  input wire logic ara_won,
  input wire logic alert_o,
  input wire logic [2:0] full_scale_span,
  input wire logic [27:0] lsb_pv,
  input wire logic modulator_clock_en
);
  localparam int PER = 4 * CLK_PER_OSC;
  int mc;
  logic seen;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========
  // gap between modulator ticks; first gap after reset is not judged
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mc <= 0;
      seen <= 1'b0;
    end else begin
      mc <= modulator_clock_en ? 0 : mc + 1;
      seen <= seen | modulator_clock_en;
    end
  end
  function automatic logic [27:0] lsb_of(input logic [2:0] s);
    if (s == 3'h0) return `ACCA_LSB_0;
    if (s == 3'h1) return `ACCA_LSB_1;
    return `ACCA_LSB_2 >> (s > 3'h5 ? 3'h3 : s - 3'h2);
  endfunction
  sequence s_end;
    ##[0:2] conv_done;
  endsequence
  property p_gap;
    modulator_clock_en && seen |-> mc == PER - 1;
  endproperty
  a_gap: assert property (p_gap) else $error("tick gap");
  property p_tick;
    converting |-> ##[0:PER] modulator_clock_en;
  endproperty
  a_tick: assert property (p_tick) else $error("no tick");
  property p_done;
    conv_done |=> !conv_done;
  endproperty
  a_done: assert property (p_done) else $error("done long");
  property p_cause;
    conv_done |-> $past(converting) || $past(converting, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("stray done");
  property p_end;
    $fell(converting) |-> s_end;
  endproperty
  a_end: assert property (p_end) else $error("no result");
  property p_lsb;
    lsb_pv != '0 |-> lsb_pv == lsb_of(full_scale_span);
  endproperty
  a_lsb: assert property (p_lsb) else $error("lsb weight");
  property p_stat;
    $changed(ara_status) |-> ##[0:1] conv_done;
  endproperty
  a_stat: assert property (p_stat) else $error("status moved");
  property p_pend;
    $fell(ara_pending) |-> $past(psel && penable) || $past(ara_cmd && ara_won);
  endproperty
  a_pend: assert property (p_pend) else $error("hold lost");
  property p_open;
    alert_o == 1'b0;
  endproperty
  a_open: assert property (p_open) else $error("pin driven");
endmodule // acca_top_props
bind acca_top acca_top_props #(.CLK_PER_OSC(CLK_PER_OSC)) i_acca_top_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pslverr(pslverr), .conv_done(conv_done), .converting(converting),
  .ara_pending(ara_pending), .ara_status(ara_status), .ara_cmd(ara_cmd),
  .ara_won(ara_won), .alert_o(alert_o), .full_scale_span(full_scale_span),
  .lsb_pv(lsb_pv), .modulator_clock_en(modulator_clock_en)
);

/* File: tb/acca_top_tb_top.sv */
// self-checking bench of the converter control block
`timescale 1ns/10ps
module acca_top_tb_top;
  import acca_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  acca_word_t sample = 16'h0;
  acca_word_t conv_data, up, lo, d;
  logic [31:0] prdata, q;
  logic [1:0] positive_input, negative_input;
  logic [2:0] full_scale_span;
  logic [27:0] lsb_pv;
  logic pready, pslverr, ara_cmd, ara_won, ara_pending, ara_status, se;
  logic alert_i, alert_o, alert_oe, neg_ground, modulator_clock_en;
  logic converting, conv_done;
  int err_total = 0;
  int check_count = 0;
  int seed = 32'h10b3;
  int cyc = 0;
  int cc, t;
  int sps[8] = '{8, 16, 32, 64, 128, 250, 475, 860};
  acca_top #(.CLK_PER_OSC(2), .MOD_HZ(2000)) i_acca_top (
    .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .conv_data, .ara_cmd, .ara_won, .ara_pending,
    .ara_status, .alert_i, .alert_o, .alert_oe, .positive_input,
    .negative_input, .neg_ground, .full_scale_span, .lsb_pv,
    .modulator_clock_en, .converting, .conv_done
  );
  acca_host_model i_acca_host_model (
    .clk_sys, .sample, .alert_oe, .conv_data, .alert_i, .ara_cmd, .ara_won
  );
  // ==========
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      wrap_up;
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic lim(input acca_word_t u, l);
    apb(1'b1, 12'h008, {16'h0, u});
    apb(1'b1, 12'h00c, {16'h0, l});
  endtask
  // counts busy cycles; oe settles one cycle after the done pulse rises
  task automatic wait_done;
    int n;
    n = 0;
    cc = 0;
    while (conv_done !== 1'b1 && n < 9000) begin
      @(negedge clk_sys);
      n++;
      if (converting === 1'b1) cc++;
    end
    chk("done", conv_done, 1'b1);
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic shot(input logic [15:0] cfg, input acca_word_t v);
    @(posedge clk_sys);
    sample <= v;
    apb(1'b1, 12'h000, {16'h0, cfg | 16'h8100});
    wait_done;
  endtask
  function automatic logic exp_win(input acca_word_t v, u, l);
    return $signed(v) > $signed(u) || $signed(v) < $signed(l);
  endfunction
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("config", q, 32'h0583);
    apb(1'b0, 12'h008, 32'h0);
    chk("upper", q, 32'h7fff);
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped", {q[30:0], se}, 32'h1);
    chk("idle pin", alert_i, 1'b1);
    lim(16'h1000, 16'h0800);
    shot(16'h6af4, 16'h2000);
    chk("window", alert_oe, 1'b1);
    chk("lsb5", lsb_pv, 28'h773594);
    chk("pos", {positive_input, neg_ground}, 3'h5);
    chk("hi", ara_status, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk("start", q[15], 1'b0);
    shot(16'h6af4, 16'h0c00);
    chk("held", ara_pending, 1'b1);
    i_acca_host_model.respond(1'b0);
    chk("lost", alert_oe, 1'b1);
    i_acca_host_model.respond(1'b1);
    repeat (2) @(negedge clk_sys);
    chk("won", alert_oe, 1'b0);
    shot(16'h6af4, 16'h0100);
    chk("lo", ara_status, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk("result", q, 32'h0100);
    repeat (2) @(negedge clk_sys);
    chk("read clr", alert_oe, 1'b0);
    shot(16'h00e0, 16'h2000);
    chk("set", alert_oe, 1'b1);
    chk("lsb0", lsb_pv, 28'hb2d05e0);
    chk("neg", {negative_input, neg_ground}, 3'h2);
    shot(16'h00e0, 16'h0c00);
    chk("keep", alert_oe, 1'b1);
    shot(16'h00e0, 16'h0100);
    chk("drop", alert_oe, 1'b0);
    shot(16'h00e1, 16'h2000);
    chk("one hit", alert_oe, 1'b0);
    shot(16'h00e1, 16'h2000);
    chk("two hits", alert_oe, 1'b1);
    shot(16'h00e3, 16'h2000);
    chk("off", alert_oe, 1'b0);
    shot(16'h00e8, 16'h0100);
    chk("act high", alert_oe, 1'b1);
    for (int i = 0; i < 8; i++) begin
      up = $random(seed) & 16'h7fff;
      lo = $random(seed);
      d = $random(seed);
      lim(up, lo);
      shot(16'h0010 | 16'(i << 5), d);
      t = 2000 / sps[i];
      chk("rand", alert_oe, exp_win(d, up, lo));
      chk("time", cc + 8 >= t * 8 && cc <= t * 8 + 8, 1'b1);
    end
    lim(16'h8000, 16'h0000);
    shot(16'h00e0, 16'h8000);
    chk("rdy one", alert_oe, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk("status", {q[4:3], q[0]}, 3'b010);
    apb(1'b1, 12'h000, 32'h0008);
    wait_done;
    chk("pulse", alert_oe, 1'b0);
    repeat (24) @(negedge clk_sys);
    chk("pulse end", alert_oe, 1'b1);
    wrap_up;
  end
endmodule // acca_top_tb_top
